/* rtl/dbi_pkg.sv */
/*
  Shared constants, state encoding and burst-order decoding for the
  burst interface.
  Assumes: one memory device with eight banks and an 8-bit data path per edge.
*/
package dbi_pkg;

  // ==========================================================
  // Widths and storage shape
  localparam int DQ_W       = 8;
  localparam int BEATS      = 8;
  localparam int BANKS      = 8;
  localparam int BA_W       = 3;
  localparam int ADDR_W     = 14;
  localparam int GRP_W      = 2;
  localparam int ROW_KEEP_W = 1;
  localparam int IDX_W      = BA_W + ROW_KEEP_W + GRP_W;
  localparam int MEM_DEPTH  = 1 << IDX_W;

  // ==========================================================
  // Address field positions
  localparam int COL_LSB  = 0;
  localparam int GRP_LSB  = 3;
  localparam int AP_BIT   = 10;
  localparam int CHOP_BIT = 12;

  // ==========================================================
  // Command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;

  // ==========================================================
  // Latencies in link clock cycles
  localparam logic [2:0] WL_CYC    = 3'h5;
  localparam logic [2:0] RL_CYC    = 3'h6;
  localparam logic [2:0] WL_PRE    = WL_CYC - 3'h1;
  localparam logic [2:0] RL_PRE    = RL_CYC - 3'h2;
  localparam logic [2:0] PAIRS_BL8 = 3'h3;
  localparam logic [2:0] PAIRS_BC4 = 3'h1;

  // ==========================================================
  // Byte masks for a full or chopped write
  localparam logic [BEATS-1:0] MASK_ALL = 8'hff;
  localparam logic [BEATS-1:0] MASK_LO  = 8'h0f;
  localparam logic [BEATS-1:0] MASK_HI  = 8'hf0;

  // ==========================================================
  // Link-side states
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_WR_WAIT = 6'h02,
    ST_WR_DATA = 6'h04,
    ST_RD_WAIT = 6'h08,
    ST_RD_PRE  = 6'h10,
    ST_RD_DATA = 6'h20
  } dbi_state_t;

  // Sequential order; a chopped burst wraps inside its nibble
  function automatic logic [2:0] dbi_beat_pos(
    input logic [2:0] start,
    input logic       chop,
    input logic [2:0] beat
  );
    logic [1:0] low;
    logic [2:0] full;
    low  = start[1:0] + beat[1:0];
    full = start + beat;
    return chop ? {start[2], low} : full;
  endfunction : dbi_beat_pos

endpackage : dbi_pkg

/* rtl/dbi_sync3.sv */
/*
  Three-stage level synchroniser with agreement filter.
  Assumes: d is a slow level or toggle; q follows once stages two and three agree.
*/
`timescale 1ns/1ps
module dbi_sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic s1;
  logic s2;
  logic s3;

  // ==========================================================
  // Stages
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q  <= 1'b0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q <= s3;
    end
  end

endmodule : dbi_sync3

/* rtl/dbi_burst_if.sv */
/*
  Device-side command, address and burst data interface of an eight-bank
  double-data-rate memory, with the array kept in the system clock domain.
  Assumes: pins are synchronous to diff_clock_true; each pin pair carries the
  rising-half and falling-half words of one link cycle.
*/
// Summary of operation
// [R1] Two data words move per link cycle; core word is eight pin widths.
// [R2] One access is one core word over four link cycles, eight half beats.
// [R3] Controller centres write strobe edges in the data eye.
// [R4] Read strobe is driven with edges on the read data transitions.
// [R5] Command, control and address are sampled on each rising link clock.
// [R6] First write beat is taken on first strobe rise after the preamble.
// [R7] First read beat follows the read preamble on the first strobe rise.
// [R8] Bursts start at the chosen column and run in sequential order.
// [R9] Controller opens a row before reading or writing that bank.
// [R10] Activate uses its bank and address bits to pick bank and row.
// [R11] Read or write uses its bank and address bits for bank and column.
// [R12] Bursts are eight beats or chopped to four beats.
// [R13] Auto precharge closes the row itself at the end of the burst.
// [R14] Banks work concurrently; activate or precharge during another burst.
// [R15] Self refresh and a separate power-down mode are provided.
// [R16] Above 85 C the controller doubles refresh and picks hot self refresh.
// [R17] With on-the-fly chop, address bit 12 high gives eight, low gives four.
// [R18] Chip select high masks every command.
`timescale 1ns/1ps
module dbi_burst_if
  import dbi_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              diff_clock_true,
  input  wire logic              diff_clock_comp,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BA_W-1:0]   ba,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DQ_W-1:0]   dq_in_rise,
  input  wire logic [DQ_W-1:0]   dq_in_fall,
  input  wire logic              dqs_in,
  input  wire logic              otf_enable,
  input  wire logic              fixed_chop,
  output logic [DQ_W-1:0]        dq_out_rise,
  output logic [DQ_W-1:0]        dq_out_fall,
  output logic                   dq_oe,
  output logic                   dqs_out,
  output logic                   dqs_oe,
  output logic [BANKS-1:0]       bank_open,
  output logic                   self_refresh_on,
  output logic                   power_down_on
);

  // ==========================================================
  // Link domain reset
  // Complement clock only shapes the crossing point off chip.
  logic link_rst_n;

  dbi_sync3 u_link_rst (
    .clk   (diff_clock_true),
    .rst_n (1'b1),
    .d     (rstn),
    .q     (link_rst_n)
  );

  // ==========================================================
  // Command decode
  logic [2:0]            cmd;
  logic                  cmd_live;
  logic                  is_act;
  logic                  is_pre;
  logic                  is_rd;
  logic                  is_wr;
  logic                  is_ref;
  dbi_state_t            st;
  dbi_state_t            next_st;
  logic [2:0]            cnt;
  logic [2:0]            next_cnt;
  logic [BA_W-1:0]       cur_bank;
  logic [2:0]            cur_col;
  logic [GRP_W-1:0]      cur_grp;
  logic [ROW_KEEP_W-1:0] cur_row;
  logic                  cur_chop;
  logic                  cur_ap;
  logic [ROW_KEEP_W-1:0] bank_row [BANKS];
  logic                  idle;
  logic                  acc_ok;
  logic                  rd_go;
  logic                  wr_go;
  logic                  chop_sel;
  logic                  last_pair;
  logic                  beat_ok;
  logic                  burst_end;
  logic                  go_pre;
  logic                  ack_s;
  logic                  ack_ok;
  logic                  cnt_inc;
  logic                  cnt_hold;
  logic                  rd_tgl;
  logic                  wr_tgl;

  assign cmd      = {ras_n, cas_n, we_n};
  assign cmd_live = !cs_n && cke && !self_refresh_on && !power_down_on; // [R18] [R5]
  assign is_act   = cmd_live && (cmd == CMD_ACT);
  assign is_pre   = cmd_live && (cmd == CMD_PRE);
  assign is_rd    = cmd_live && (cmd == CMD_RD);
  assign is_wr    = cmd_live && (cmd == CMD_WR);
  assign is_ref   = !cs_n && (cmd == CMD_REF);
  assign idle     = (st == ST_IDLE);
  // Access to a closed bank is dropped
  assign acc_ok   = idle && bank_open[ba]; // [R9]
  assign rd_go    = is_rd && acc_ok;
  assign wr_go    = is_wr && acc_ok;
  assign chop_sel = otf_enable ? !addr[CHOP_BIT] : fixed_chop; // [R17] [R12]

  // ==========================================================
  // Burst sequencing
  assign last_pair = (cnt == (cur_chop ? PAIRS_BC4 : PAIRS_BL8)); // [R12]
  assign beat_ok   = (st == ST_WR_DATA) && dqs_in; // [R6] [R3]
  assign burst_end = (beat_ok || (st == ST_RD_DATA)) && last_pair;
  assign ack_ok    = (ack_s == rd_tgl);
  assign go_pre    = (st == ST_RD_WAIT) && (cnt >= RL_PRE) && ack_ok;
  assign cnt_inc   = ((st == ST_WR_WAIT) && (cnt != WL_PRE)) || beat_ok
                   || (st == ST_RD_DATA) || ((st == ST_RD_WAIT) && (cnt < RL_PRE));
  assign cnt_hold  = (st == ST_WR_DATA) || ((st == ST_RD_WAIT) && !go_pre);
  assign next_cnt  = cnt_inc ? 3'(cnt + 3'h1) : (cnt_hold ? cnt : 3'h0);

  always_comb
  begin
    next_st = st;
    unique case (st)
      ST_IDLE:
        if (rd_go)
          next_st = ST_RD_WAIT;
        else if (wr_go)
          next_st = ST_WR_WAIT;
      ST_WR_WAIT:
        if (cnt == WL_PRE)
          next_st = ST_WR_DATA;
      ST_WR_DATA:
        if (burst_end)
          next_st = ST_IDLE;
      ST_RD_WAIT:
        if (go_pre)
          next_st = ST_RD_PRE;
      ST_RD_PRE:
        next_st = ST_RD_DATA;
      ST_RD_DATA:
        if (burst_end)
          next_st = ST_IDLE;
      default:
        next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge diff_clock_true)
  begin
    if (!link_rst_n)
    begin
      st     <= ST_IDLE;
      cnt    <= 3'h0;
      rd_tgl <= 1'b0;
      wr_tgl <= 1'b0;
    end
    else
    begin
      st  <= next_st;
      cnt <= next_cnt;
      if (rd_go)
        rd_tgl <= ~rd_tgl;
      if (beat_ok && last_pair)
        wr_tgl <= ~wr_tgl;
    end
  end

  // Access target latched with the command
  always_ff @(posedge diff_clock_true)
  begin
    if (!link_rst_n)
    begin
      cur_bank <= '0;
      cur_col  <= 3'h0;
      cur_grp  <= '0;
      cur_row  <= '0;
      cur_chop <= 1'b0;
      cur_ap   <= 1'b0;
    end
    else if (rd_go || wr_go)
    begin
      cur_bank <= ba; // [R11]
      cur_col  <= addr[COL_LSB +: 3];
      cur_grp  <= addr[GRP_LSB +: GRP_W];
      cur_row  <= bank_row[ba];
      cur_chop <= chop_sel;
      cur_ap   <= addr[AP_BIT];
    end
  end

  // ==========================================================
  // Bank rows, each bank on its own
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++)
    begin : g_bank
      logic hit_act;
      logic hit_close;
      assign hit_act   = is_act && (ba == BA_W'(gb)); // [R10] [R14]
      assign hit_close = (is_pre && (addr[AP_BIT] || (ba == BA_W'(gb))))
                       || (burst_end && cur_ap && (cur_bank == BA_W'(gb))); // [R13]
      always_ff @(posedge diff_clock_true)
      begin
        if (!link_rst_n)
        begin
          bank_open[gb] <= 1'b0;
          bank_row[gb]  <= '0;
        end
        else if (hit_act)
        begin
          bank_open[gb] <= 1'b1;
          bank_row[gb]  <= addr[ROW_KEEP_W-1:0];
        end
        else if (hit_close)
          bank_open[gb] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // Power states
  always_ff @(posedge diff_clock_true)
  begin
    if (!link_rst_n)
    begin
      self_refresh_on <= 1'b0;
      power_down_on   <= 1'b0;
    end
    else if (cke)
    begin
      self_refresh_on <= 1'b0;
      power_down_on   <= 1'b0;
    end
    else if (!self_refresh_on && !power_down_on)
    begin
      self_refresh_on <= is_ref && idle; // [R15]
      power_down_on   <= !(is_ref && idle);
    end
  end

  // ==========================================================
  // Beat pairing and data path
  logic [1:0]             pidx;
  logic [2:0]             pos_r;
  logic [2:0]             pos_f;
  logic                   drive_pair;
  logic [DQ_W-1:0]        wbuf [BEATS];
  logic [BEATS*DQ_W-1:0]  rd_word;
  logic [BEATS*DQ_W-1:0]  core_rdata;
  logic [BEATS-1:0]       wmask;

  assign pidx  = (st == ST_RD_PRE) ? 2'h0 : ((st == ST_RD_DATA) ? 2'(cnt[1:0] + 2'h1) : cnt[1:0]);
  assign pos_r = dbi_beat_pos(cur_col, cur_chop, {pidx, 1'b0}); // [R8] [R1]
  assign pos_f = dbi_beat_pos(cur_col, cur_chop, {pidx, 1'b1});
  assign drive_pair = (st == ST_RD_PRE) || ((st == ST_RD_DATA) && !last_pair);
  assign wmask = !cur_chop ? MASK_ALL : (cur_col[2] ? MASK_HI : MASK_LO);

  genvar gw;
  generate
    for (gw = 0; gw < BEATS; gw++)
    begin : g_wbyte
      always_ff @(posedge diff_clock_true)
      begin
        if (beat_ok && (pos_r == 3'(gw)))
          wbuf[gw] <= dq_in_rise; // [R1] [R6]
        else if (beat_ok && (pos_f == 3'(gw)))
          wbuf[gw] <= dq_in_fall;
      end
    end
  endgenerate

  // Strobe high with each data pair, low for the preamble cycle
  always_ff @(posedge diff_clock_true)
  begin
    if (!link_rst_n)
    begin
      dq_oe       <= 1'b0;
      dqs_out     <= 1'b0;
      dqs_oe      <= 1'b0;
      dq_out_rise <= '0;
      dq_out_fall <= '0;
      rd_word     <= '0;
    end
    else
    begin
      dq_oe   <= drive_pair;
      dqs_out <= drive_pair; // [R4]
      dqs_oe  <= go_pre || drive_pair; // [R7]
      if (go_pre)
        rd_word <= core_rdata;
      if (drive_pair)
      begin
        dq_out_rise <= rd_word[pos_r*DQ_W +: DQ_W];
        dq_out_fall <= rd_word[pos_f*DQ_W +: DQ_W];
      end
    end
  end

  // ==========================================================
  // Core array on the system clock
  // Target and write data stay still for a full link cycle after each toggle.
  logic [BEATS*DQ_W-1:0] mem [MEM_DEPTH];
  logic [IDX_W-1:0]      acc_idx;
  logic                  wr_s;
  logic                  rd_s;
  logic                  wr_seen;
  logic                  rd_seen;
  logic                  rd_ack_t;
  logic                  wr_ev;
  logic                  rd_ev;

  dbi_sync3 u_wr_sync (
    .clk   (clk_sys),
    .rst_n (rstn),
    .d     (wr_tgl),
    .q     (wr_s)
  );

  dbi_sync3 u_rd_sync (
    .clk   (clk_sys),
    .rst_n (rstn),
    .d     (rd_tgl),
    .q     (rd_s)
  );

  dbi_sync3 u_ack_sync (
    .clk   (diff_clock_true),
    .rst_n (link_rst_n),
    .d     (rd_ack_t),
    .q     (ack_s)
  );

  assign acc_idx = {cur_bank, cur_row, cur_grp};
  assign wr_ev   = (wr_s != wr_seen);
  assign rd_ev   = (rd_s != rd_seen);

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wr_seen    <= 1'b0;
      rd_seen    <= 1'b0;
      rd_ack_t   <= 1'b0;
      core_rdata <= '0;
    end
    else
    begin
      wr_seen <= wr_s;
      rd_seen <= rd_s;
      if (rd_ev)
      begin
        core_rdata <= mem[acc_idx]; // [R2]
        rd_ack_t   <= ~rd_ack_t;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (wr_ev)
      for (int b = 0; b < BEATS; b++)
        if (wmask[b])
          mem[acc_idx][b*DQ_W +: DQ_W] <= wbuf[b]; // [R2]
  end

  // ==========================================================
  // Checks
  sequence s_pre_cycle;
    dqs_oe && !dqs_out && !dq_oe;
  endsequence

  sequence s_data8;
    (dq_oe && dqs_out && (st == ST_RD_DATA)) [*4] ##1 !dq_oe;
  endsequence

  sequence s_data4;
    (dq_oe && dqs_out && (st == ST_RD_DATA)) [*2] ##1 !dq_oe;
  endsequence

  a_cs_masks_cmd: assert property ( // [R18]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    idle && cs_n |=> idle && $stable(bank_open))
    else $error("command taken with chip select high");

  a_act_opens_row: assert property ( // [R10] [R14]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    is_act |=> bank_open[$past(ba)])
    else $error("activate did not open bank");

  a_rd_target_taken: assert property ( // [R11]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    rd_go |=> (cur_bank == $past(ba)) && (cur_col == $past(addr[2:0])))
    else $error("read target not latched");

  a_rd_burst_eight: assert property ( // [R2] [R12]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    $rose(st == ST_RD_PRE) && !cur_chop |-> s_pre_cycle ##1 s_data8)
    else $error("eight beat read burst malformed");

  a_rd_burst_four: assert property ( // [R12]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    $rose(st == ST_RD_PRE) && cur_chop |-> s_pre_cycle ##1 s_data4)
    else $error("chopped read burst malformed");

  a_strobe_with_data: assert property ( // [R4] [R7]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    dq_oe |-> dqs_oe && dqs_out && $past(dqs_oe))
    else $error("read data without strobe");

  a_wr_waits_strobe: assert property ( // [R6]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    (st == ST_WR_DATA) && !dqs_in |=> (st == ST_WR_DATA) && $stable(cnt))
    else $error("write beat taken without strobe");

  a_auto_close: assert property ( // [R13]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    burst_end && cur_ap |=> !bank_open[$past(cur_bank)] && idle)
    else $error("auto precharge left row open");

  a_self_refresh: assert property ( // [R15]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    !cke && is_ref && idle && !self_refresh_on && !power_down_on |=> self_refresh_on ##1 (cke or self_refresh_on))
    else $error("self refresh not entered");

  a_chop_select: assert property ( // [R17]
    @(posedge diff_clock_true) disable iff (!link_rst_n)
    (rd_go || wr_go) && otf_enable |=> cur_chop == !$past(addr[CHOP_BIT]))
    else $error("on the fly chop ignored");

endmodule : dbi_burst_if

/* bench/dbi_ctrl_model.sv */
/*
  Behavioural memory controller driving the link side of the burst interface.
  Assumes: tasks are entered at a falling link edge, which is why every
  request is held across exactly one rising edge.
*/
`timescale 1ns/1ps
module dbi_ctrl_model
  import dbi_pkg::*;
(
  input  wire logic              diff_clock_true,
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [BA_W-1:0]        ba,
  output logic [ADDR_W-1:0]      addr,
  output logic [DQ_W-1:0]        dq_in_rise,
  output logic [DQ_W-1:0]        dq_in_fall,
  output logic                   dqs_in
);
  initial
  begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = '0;
    addr = '0;
    dq_in_rise = '0;
    dq_in_fall = '0;
    dqs_in = 1'b0;
  end

  // ==========================================================
  // Command slot
  task automatic cmd(input logic sel_n, input logic ke, input logic [2:0] code,
                     input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
    cs_n = sel_n;
    cke = ke;
    {ras_n, cas_n, we_n} = code;
    ba = b;
    addr = a;
    @(negedge diff_clock_true);
    // Released bus carries inverted leftovers so stale values cannot match
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~code;
    ba = ~b;
    addr = ~a;
  endtask : cmd

  // ==========================================================
  // Write data, one pair per link cycle, mid-cycle against the rising edge
  task automatic wdata(input logic [BEATS*DQ_W-1:0] d, input int np, input int gap);
    repeat (4) @(negedge diff_clock_true);
    for (int p = 0; p < np; p++)
    begin
      @(negedge diff_clock_true);
      // A low strobe cycle before pair gap stalls the burst
      if (p == gap)
      begin
        dqs_in = 1'b0;
        @(negedge diff_clock_true);
      end
      dq_in_rise = d[2*DQ_W*p +: DQ_W];
      dq_in_fall = d[2*DQ_W*p+DQ_W +: DQ_W];
      dqs_in = 1'b1;
    end
    @(negedge diff_clock_true);
    dqs_in = 1'b0;
    dq_in_rise = ~dq_in_rise;
    dq_in_fall = ~dq_in_fall;
  endtask : wdata
endmodule : dbi_ctrl_model

/* bench/dbi_burst_if_test.sv */
/*
  Self-checking bench for the burst interface with a controller model.
  Assumes: link clock free-running at 80 ns; bench drives on falling link edges, except rstn and the chop controls on falling clk_sys edges.
*/
`timescale 1ns/1ps
module dbi_burst_if_test;
  import dbi_pkg::*;
  logic clk_sys, rstn, diff_clock_true, otf_enable, fixed_chop;
  logic cke, cs_n, ras_n, cas_n, we_n, dqs_in, dq_oe, dqs_out, dqs_oe, self_refresh_on, power_down_on;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   dq_in_rise, dq_in_fall, dq_out_rise, dq_out_fall;
  logic [BANKS-1:0]  bank_open;
  logic [7:0]        shadow [8];
  int                bad_count, total_checks, cycles;

  dbi_ctrl_model i_dbi_ctrl_model (.diff_clock_true(diff_clock_true), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall),
    .dqs_in(dqs_in));
  dbi_burst_if i_dbi_burst_if (.clk_sys(clk_sys), .rstn(rstn), .diff_clock_true(diff_clock_true),
    .diff_clock_comp(~diff_clock_true), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall), .dqs_in(dqs_in),
    .otf_enable(otf_enable), .fixed_chop(fixed_chop), .dq_out_rise(dq_out_rise), .dq_out_fall(dq_out_fall),
    .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .bank_open(bank_open),
    .self_refresh_on(self_refresh_on), .power_down_on(power_down_on));

  // ==========================================================
  // Clocks, timeout and reporting
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Odd offset keeps the link clock out of phase with the system clock
  initial
  begin
    diff_clock_true = 1'b0;
    #13;
    forever #40 diff_clock_true = ~diff_clock_true;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  function automatic logic [ADDR_W-1:0] mk_addr(input logic [2:0] col, input logic ap, input logic a12);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[COL_LSB +: 3] = col;
    a[AP_BIT] = ap;
    a[CHOP_BIT] = a12;
    return a;
  endfunction : mk_addr

  // Chopped bursts wrap inside the nibble holding the start column
  function automatic logic [2:0] beat_col(input logic [2:0] col, input logic chop, input int i);
    logic [2:0] s;
    s = col + 3'(i);
    return chop ? {col[2], s[1:0]} : s;
  endfunction : beat_col

  // ==========================================================
  // Read burst with full cycle-by-cycle judgement
  task automatic rd_check(input logic [2:0] col, input logic a12, input logic chop, input logic ap,
                          input logic conc, input logic [BANKS-1:0] exp_open);
    int np;
    np = chop ? 2 : 4;
    i_dbi_ctrl_model.cmd(1'b0, 1'b1, CMD_RD, 3'h2, mk_addr(col, ap, a12));
    for (int j = 1; j <= 7 + np; j++)
    begin
      if (conc && j == 6) i_dbi_ctrl_model.cmd(1'b0, 1'b1, CMD_ACT, 3'h4, 14'h0000);
      else @(negedge diff_clock_true);
      if (j == 4) chk_bit(dqs_oe, 1'b0);
      if (j == 5) chk_bit(dqs_oe, 1'b1);
      if (j == 5) chk_bit(dqs_out | dq_oe, 1'b0);
      if (j >= 6 && j < 6 + np) chk_bit(dqs_out & dq_oe, 1'b1);
      if (j >= 6 && j < 6 + np) chk_val({8'h00, dq_out_rise}, {8'h00, shadow[beat_col(col, chop, 2*(j-6))]});
      if (j >= 6 && j < 6 + np) chk_val({8'h00, dq_out_fall}, {8'h00, shadow[beat_col(col, chop, 2*(j-6)+1)]});
      if (j == 6 + np) chk_bit(dq_oe | dqs_oe, 1'b0);
      if (j == 7 + np) chk_val({8'h00, bank_open}, {8'h00, exp_open});
    end
  endtask : rd_check

  // ==========================================================
  // Scenarios
  task automatic t_activate();
    chk_val({8'h00, bank_open}, 16'h0000);
    i_dbi_ctrl_model.cmd(1'b1, 1'b1, CMD_ACT, 3'h3, 14'h0000);
    i_dbi_ctrl_model.cmd(1'b0, 1'b1, CMD_ACT, 3'h2, 14'h0000);
    @(negedge diff_clock_true);
    chk_val({8'h00, bank_open}, 16'h0004);
    i_dbi_ctrl_model.cmd(1'b0, 1'b1, CMD_RD, 3'h5, mk_addr(3'h0, 1'b0, 1'b1));
    repeat (8)
    begin
      @(negedge diff_clock_true);
      chk_bit(dqs_oe, 1'b0);
    end
  endtask : t_activate

  task automatic t_write_read();
    logic [63:0] d;
    d = 64'h8f7e6d5c4b3a2918;
    i_dbi_ctrl_model.cmd(1'b0, 1'b1, CMD_WR, 3'h2, mk_addr(3'h5, 1'b0, 1'b1));
    i_dbi_ctrl_model.wdata(d, 4, 4);
    for (int i = 0; i < 8; i++) shadow[beat_col(3'h5, 1'b0, i)] = d[8*i +: 8];
    @(negedge diff_clock_true);
    rd_check(3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h04);
    rd_check(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 8'h04);
    // Chopped write with one stalled strobe; the other nibble must survive
    i_dbi_ctrl_model.cmd(1'b0, 1'b1, CMD_WR, 3'h2, mk_addr(3'h2, 1'b0, 1'b0));
    i_dbi_ctrl_model.wdata(~d, 2, 1);
    for (int i = 0; i < 4; i++) shadow[beat_col(3'h2, 1'b1, i)] = ~d[8*i +: 8];
    @(negedge diff_clock_true);
    rd_check(3'h7, 1'b1, 1'b0, 1'b0, 1'b0, 8'h04);
  endtask : t_write_read

  task automatic t_chop();
    rd_check(3'h6, 1'b0, 1'b1, 1'b0, 1'b0, 8'h04);
    @(negedge clk_sys);
    otf_enable = 1'b0;
    fixed_chop = 1'b1;
    @(negedge diff_clock_true);
    rd_check(3'h1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h04);
    @(negedge clk_sys);
    fixed_chop = 1'b0;
    @(negedge diff_clock_true);
    rd_check(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 8'h04);
    @(negedge clk_sys);
    otf_enable = 1'b1;
    @(negedge diff_clock_true);
    rd_check(3'h4, 1'b1, 1'b0, 1'b1, 1'b1, 8'h10);
  endtask : t_chop

  task automatic t_power();
    i_dbi_ctrl_model.cmd(1'b0, 1'b1, CMD_PRE, 3'h4, 14'h0000);
    @(negedge diff_clock_true);
    chk_val({8'h00, bank_open}, 16'h0000);
    // Controller picks self refresh; a hot part would also double refresh
    i_dbi_ctrl_model.cmd(1'b0, 1'b0, CMD_REF, 3'h0, 14'h0000);
    @(negedge diff_clock_true);
    chk_bit(self_refresh_on, 1'b1);
    chk_bit(power_down_on, 1'b0);
    i_dbi_ctrl_model.cmd(1'b1, 1'b1, CMD_REF, 3'h0, 14'h0000);
    @(negedge diff_clock_true);
    chk_bit(self_refresh_on, 1'b0);
    i_dbi_ctrl_model.cmd(1'b1, 1'b0, CMD_REF, 3'h0, 14'h0000);
    @(negedge diff_clock_true);
    chk_bit(power_down_on, 1'b1);
    chk_bit(self_refresh_on, 1'b0);
    i_dbi_ctrl_model.cmd(1'b1, 1'b1, CMD_REF, 3'h0, 14'h0000);
    @(negedge diff_clock_true);
    chk_bit(power_down_on, 1'b0);
  endtask : t_power

  // ==========================================================
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    otf_enable = 1'b1;
    fixed_chop = 1'b0;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    // Link domain needs several link edges of reset, far more than five system cycles
    repeat (10) @(negedge diff_clock_true);
    chk_bit(dqs_oe | dq_oe, 1'b0);
    @(negedge clk_sys);
    rstn = 1'b1;
    repeat (6) @(negedge diff_clock_true);
    t_activate();
    t_write_read();
    t_chop();
    t_power();
    conclude();
  end
endmodule : dbi_burst_if_test
